// [rtl/power_status_pkg.sv]
// constants, field layout and types shared by the power status block
package power_status_pkg;

  // register indices: byte address is four times the index, decoded on index bits 9:0
  localparam logic [31:0] IDX_ANALOG_STATUS = 32'h5000002a;
  localparam logic [31:0] IDX_CRYSTAL_START_TRIM = 32'h50000030;
  localparam logic [31:0] IDX_CRYSTAL_READY_DELAY = 32'h50000034;
  localparam logic [31:0] IDX_CRYSTAL_CORE_CONTROL = 32'h50000038;
  localparam logic [31:0] IDX_PIN_RESET_SELECT = 32'h50000040;
  localparam logic [31:0] IDX_PIN_RESET_TIMER = 32'h50000042;
  localparam logic [31:0] IDX_REFERENCE_REFRESH_INTERVAL = 32'h50000050;
  localparam logic [31:0] IDX_SUPERVISOR_CONTROL = 32'h50000060;
  localparam logic [31:0] IDX_EVENT_ENABLE = 32'h50000061;
  localparam logic [31:0] IDX_EVENT_STATUS = 32'h50000062;
  localparam logic [31:0] IDX_EVENT_CLEAR = 32'h50000063;
  localparam int DEC_BITS = 10;

  // analog status bit positions
  localparam int ST_CORE_REG = 0;
  localparam int ST_LOW_REG = 1;
  localparam int ST_SWITCHER = 2;
  localparam int ST_CMP_HIGH_OK = 3;
  localparam int ST_CMP_HIGH_NOK = 4;
  localparam int ST_BANDGAP = 5;
  localparam int ST_RAIL_LOW = 6;
  localparam int ST_RAIL_HIGH = 7;
  localparam int ST_BOOST = 8;
  localparam int ST_CRYSTAL_REG = 9;
  localparam int ST_CONVERTER_REG = 10;
  localparam int ST_WAKE_TREE = 12;

  // pin reset select layout
  localparam int PIN_POLARITY_BIT = 7;
  localparam logic [3:0] PIN_SEL_FIRST = 4'h1;
  localparam logic [3:0] PIN_SEL_LAST = 4'hc;

  // supervisor control bits
  localparam int CTL_CRYSTAL_ENABLE = 0;
  localparam int CTL_WAKE_SENSE = 1;
  localparam int CTL_MASK_RAIL_HIGH = 2;
  localparam int CTL_MASK_RAIL_LOW = 3;

  // event bits
  localparam int EV_CRYSTAL_READY = 0;
  localparam int EV_PIN_RESET = 1;
  localparam int EV_WAKE = 2;
  localparam int EVENT_BITS = 3;

  // reset values
  localparam logic [15:0] RST_CRYSTAL_START_TRIM = 16'h00aa;
  localparam logic [7:0] RST_CRYSTAL_READY_COUNT = 8'h00;
  localparam logic [15:0] RST_CRYSTAL_CORE_CONTROL = 16'h0015;
  localparam logic [7:0] RST_PIN_RESET_SELECT = 8'h00;
  localparam logic [6:0] RST_PIN_RESET_TIME = 7'h18;
  localparam logic [11:0] RST_REFRESH_UNITS = 12'h080;
  localparam logic [3:0] RST_SUPERVISOR_CONTROL = 4'h0;

  // timing
  localparam int CLK_PERIOD_NS = 4;
  localparam int REFRESH_UNIT_NS = 2000000;
  localparam int REFRESH_UNIT_CYCLES = REFRESH_UNIT_NS / CLK_PERIOD_NS;
  localparam logic [12:0] PIN_TICKS_PER_UNIT = 13'h1000;

  typedef enum logic [1:0] {
    PR_IDLE = 2'b00,
    PR_COUNT = 2'b01,
    PR_FIRED = 2'b10
  } pin_reset_state_t;

  function automatic logic regHit(input logic [31:0] addr, input logic [31:0] idx);
    regHit = (addr[DEC_BITS+1:2] == idx[DEC_BITS-1:0]);
  endfunction

endpackage

// [rtl/in_sync.sv]
// three-stage input synchroniser that accepts a change once stages two and three agree
`timescale 1ns/1ps
`default_nettype none
module in_sync #(
  parameter int W = 1
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // raw and filtered levels
  input wire logic [W-1:0] rawIn,
  output logic [W-1:0] syncOut
);
  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [W-1:0] out_d;

  assign out_d = (s2_q ~^ s3_q) & s3_q | ~(s2_q ~^ s3_q) & syncOut;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      syncOut <= '0;
    end
    else
    begin
      s1_q <= rawIn;
      s2_q <= s1_q;
      s3_q <= s2_q;
      syncOut <= out_d;
    end
  end
endmodule
`default_nettype wire

// [rtl/event_irq.sv]
// sticky event status, enable gating and one level interrupt
`timescale 1ns/1ps
`default_nettype none
module event_irq
  import power_status_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // events and software control
  input wire logic [EVENT_BITS-1:0] setPulse,
  input wire logic [EVENT_BITS-1:0] clearPulse,
  input wire logic [EVENT_BITS-1:0] enable,
  // status and interrupt
  output logic [EVENT_BITS-1:0] status_q,
  output logic irq_q
);
  logic [EVENT_BITS-1:0] status_d;

  // a set arriving with its clear survives
  assign status_d = setPulse | (status_q & ~clearPulse);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      status_q <= '0;
      irq_q <= 1'b0;
    end
    else
    begin
      status_q <= status_d;
      irq_q <= |(status_d & enable);
    end
  end
endmodule
`default_nettype wire

// [rtl/power_status_and_pin_reset.sv]
// power status word, crystal ready delay, pin reset timer and reference refresh behind apb
//
// Decided for this implementation: the APB register port.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - status bit 12 shows the wake tree output; zero wakes from hibernation
// - bits 7 and 6 show rail monitors; zero resets unless masked
// - bit 8 reads zero for buck, one for boost detected
// - bandgap, switcher, core, crystal, converter good flags read directly
// - low regulator good on bit 1 only counts in high-current mode
// - crystal ready interrupt after programmed 32 kHz cycles; zero means none
// - polarity bit 7: zero active low, one active high, gpio only
// - reset pad is always active low, polarity bit ignored
// - select 0 disables, 1 to 12 pick pins 0 to 11, rest reserved
// - power-on reset once selected pin held active for programmed time
// - reset time is field times 4096 slow rc periods, default 0x18
// - time field zero disables the pin reset timer
// - reference refresh every field times 2 ms, reset value 0x80
module power_status_and_pin_reset
  import power_status_pkg::*;
#(
  parameter int REFRESH_CYCLES = REFRESH_UNIT_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // analog monitor levels
  input wire logic railHighGood,
  input wire logic railLowGood,
  input wire logic boostDetected,
  input wire logic bandgapGood,
  input wire logic switcher_output_good,
  input wire logic core_regulator_good,
  input wire logic low_regulator_good,
  input wire logic lowRegHighCurrent,
  input wire logic crystal_regulator_good,
  input wire logic converter_regulator_good,
  input wire logic compHighOk,
  input wire logic compHighNok,
  input wire logic wake_tree_output,
  input wire logic hibernating,
  // slow clocks sampled as levels
  input wire logic clk32k,
  input wire logic slow_rc_clock,
  // reset sources
  input wire logic [11:0] portPins,
  input wire logic resetPad_n,
  // supervisor outputs
  output logic porReset_q,
  output logic railReset_q,
  output logic wakeRequest_q,
  output logic bandgapRefresh_q,
  output logic hibernate_wake_sense,
  output logic crystal_ready_interrupt
);
  localparam int SYNC_W = 29;
  localparam logic [18:0] REFRESH_LAST = 19'(REFRESH_CYCLES - 1);

  // ************************************************
  // input synchronisation
  // ************************************************
  logic [SYNC_W-1:0] rawVec;
  logic [SYNC_W-1:0] syncVec;
  logic [15:0] statusWord;
  logic [11:0] pinSync;
  logic padActive;
  logic clk32kSync;
  logic slowRcSync;
  logic clk32kPrev_q;
  logic slowRcPrev_q;
  logic tick32k;
  logic tickRc;

  // the pad is inverted first so the reset state of the sync chain means idle
  assign rawVec = {~resetPad_n, slow_rc_clock, clk32k, portPins, hibernating, wake_tree_output,
                   compHighNok, compHighOk, converter_regulator_good, crystal_regulator_good,
                   lowRegHighCurrent, low_regulator_good, core_regulator_good, switcher_output_good,
                   bandgapGood, boostDetected, railLowGood, railHighGood};

  in_sync #(.W(SYNC_W)) inputSync (
    .clk(clk),
    .rst_n(rst_n),
    .rawIn(rawVec),
    .syncOut(syncVec)
  );

  logic sRailHigh;
  logic sRailLow;
  logic sBoost;
  logic sBandgap;
  logic sSwitcher;
  logic sCoreReg;
  logic sLowReg;
  logic sLowHighCur;
  logic sCrystalReg;
  logic sConverterReg;
  logic sCmpOk;
  logic sCmpNok;
  logic sWakeTree;
  logic sHibernating;

  assign {padActive, slowRcSync, clk32kSync, pinSync, sHibernating, sWakeTree, sCmpNok, sCmpOk,
          sConverterReg, sCrystalReg, sLowHighCur, sLowReg, sCoreReg, sSwitcher, sBandgap,
          sBoost, sRailLow, sRailHigh} = syncVec;
  assign tick32k = clk32kSync & ~clk32kPrev_q;
  assign tickRc = slowRcSync & ~slowRcPrev_q;

  // ************************************************
  // analog status word
  // ************************************************
  assign statusWord[15:13] = 3'h0;
  assign statusWord[ST_WAKE_TREE] = sWakeTree;
  assign statusWord[11] = 1'b0;
  assign statusWord[ST_CONVERTER_REG] = sConverterReg;
  assign statusWord[ST_CRYSTAL_REG] = sCrystalReg;
  assign statusWord[ST_BOOST] = sBoost;
  assign statusWord[ST_RAIL_HIGH] = sRailHigh;
  assign statusWord[ST_RAIL_LOW] = sRailLow;
  assign statusWord[ST_BANDGAP] = sBandgap;
  assign statusWord[ST_CMP_HIGH_NOK] = sCmpNok;
  assign statusWord[ST_CMP_HIGH_OK] = sCmpOk;
  assign statusWord[ST_SWITCHER] = sSwitcher;
  // outside high-current mode the flag is not trustworthy, so it reads zero
  assign statusWord[ST_LOW_REG] = sLowReg & sLowHighCur;
  assign statusWord[ST_CORE_REG] = sCoreReg;

  // ************************************************
  // apb register file
  // ************************************************
  logic [15:0] startTrim_q;
  logic [7:0] readyCount_q;
  logic [15:0] coreCtrl_q;
  logic [7:0] pinSelect_q;
  logic [6:0] pinTime_q;
  logic [11:0] refreshUnits_q;
  logic [3:0] control_q;
  logic [EVENT_BITS-1:0] eventEnable_q;
  logic [EVENT_BITS-1:0] eventStatus;
  logic [EVENT_BITS-1:0] eventSet;
  logic [EVENT_BITS-1:0] eventClear;
  logic accessPhase;
  logic xfer;
  logic wr;
  logic hitStatus;
  logic hitStart;
  logic hitReady;
  logic hitCore;
  logic hitPinSel;
  logic hitPinTime;
  logic hitRefresh;
  logic hitControl;
  logic hitEnable;
  logic hitEvStatus;
  logic hitEvClear;
  logic mapped;
  logic [31:0] readMux;

  assign accessPhase = psel & penable;
  assign xfer = accessPhase & pready;
  assign wr = xfer & pwrite & ~pslverr;
  assign hitStatus = regHit(paddr, IDX_ANALOG_STATUS);
  assign hitStart = regHit(paddr, IDX_CRYSTAL_START_TRIM);
  assign hitReady = regHit(paddr, IDX_CRYSTAL_READY_DELAY);
  assign hitCore = regHit(paddr, IDX_CRYSTAL_CORE_CONTROL);
  assign hitPinSel = regHit(paddr, IDX_PIN_RESET_SELECT);
  assign hitPinTime = regHit(paddr, IDX_PIN_RESET_TIMER);
  assign hitRefresh = regHit(paddr, IDX_REFERENCE_REFRESH_INTERVAL);
  assign hitControl = regHit(paddr, IDX_SUPERVISOR_CONTROL);
  assign hitEnable = regHit(paddr, IDX_EVENT_ENABLE);
  assign hitEvStatus = regHit(paddr, IDX_EVENT_STATUS);
  assign hitEvClear = regHit(paddr, IDX_EVENT_CLEAR);
  assign mapped = hitStatus | hitStart | hitReady | hitCore | hitPinSel | hitPinTime | hitRefresh |
                  hitControl | hitEnable | hitEvStatus | hitEvClear;
  assign eventClear = (wr && hitEvClear) ? pwdata[EVENT_BITS-1:0] : '0;
  assign readMux = hitStatus ? {16'h0, statusWord} :
                   hitStart ? {16'h0, startTrim_q} :
                   hitReady ? {24'h0, readyCount_q} :
                   hitCore ? {16'h0, coreCtrl_q} :
                   hitPinSel ? {24'h0, pinSelect_q} :
                   hitPinTime ? {25'h0, pinTime_q} :
                   hitRefresh ? {20'h0, refreshUnits_q} :
                   hitControl ? {28'h0, control_q} :
                   hitEnable ? {29'h0, eventEnable_q} :
                   hitEvStatus ? {29'h0, eventStatus} : 32'h0;

  // one wait state: ready comes from a flop, read data is latched with it
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end
    else
    begin
      pready <= accessPhase & ~pready;
      pslverr <= accessPhase & ~pready & ~mapped;
      prdata <= (accessPhase && !pready && !pwrite) ? readMux : 32'h0;
    end
  end

  // analog status and event status have no write path
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      startTrim_q <= RST_CRYSTAL_START_TRIM;
      readyCount_q <= RST_CRYSTAL_READY_COUNT;
      coreCtrl_q <= RST_CRYSTAL_CORE_CONTROL;
      pinSelect_q <= RST_PIN_RESET_SELECT;
      pinTime_q <= RST_PIN_RESET_TIME;
      refreshUnits_q <= RST_REFRESH_UNITS;
      control_q <= RST_SUPERVISOR_CONTROL;
      eventEnable_q <= '0;
    end
    else if (wr)
    begin
      if (hitStart) startTrim_q <= pwdata[15:0];
      if (hitReady) readyCount_q <= pwdata[7:0];
      if (hitCore) coreCtrl_q <= {6'h0, pwdata[9:0] & 10'h0ff};
      if (hitPinSel) pinSelect_q <= pwdata[7:0];
      if (hitPinTime) pinTime_q <= pwdata[6:0];
      if (hitRefresh) refreshUnits_q <= pwdata[11:0];
      if (hitControl) control_q <= pwdata[3:0];
      if (hitEnable) eventEnable_q <= pwdata[EVENT_BITS-1:0];
    end
  end

  event_irq events (
    .clk(clk),
    .rst_n(rst_n),
    .setPulse(eventSet),
    .clearPulse(eventClear),
    .enable(eventEnable_q),
    .status_q(eventStatus),
    .irq_q(crystal_ready_interrupt)
  );

  // ************************************************
  // crystal ready delay
  // ************************************************
  logic [7:0] xtalCount_q;
  logic xtalDone_q;
  logic xtalFire;
  logic crystalOn;

  assign crystalOn = control_q[CTL_CRYSTAL_ENABLE];
  assign xtalFire = crystalOn & ~xtalDone_q & (readyCount_q != 8'h00) & (xtalCount_q == readyCount_q);

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      xtalCount_q <= 8'h00;
      xtalDone_q <= 1'b0;
    end
    else if (!crystalOn)
    begin
      xtalCount_q <= 8'h00;
      xtalDone_q <= 1'b0;
    end
    else
    begin
      if (tick32k && !xtalDone_q && xtalCount_q != 8'hff) xtalCount_q <= xtalCount_q + 8'h01;
      if (xtalFire) xtalDone_q <= 1'b1;
    end
  end

  // ************************************************
  // gpio pin power-on reset
  // ************************************************
  pin_reset_state_t pinState_q;
  pin_reset_state_t pinState_d;
  logic [12:0] pinTicks_q;
  logic [6:0] pinUnits_q;
  logic [3:0] pinSel;
  logic selValid;
  logic selLevel;
  logic pinActive;
  logic pinEnabled;
  logic unitDone;

  assign pinSel = pinSelect_q[3:0];
  assign selValid = (pinSel >= PIN_SEL_FIRST) && (pinSel <= PIN_SEL_LAST);
  assign selLevel = selValid ? pinSync[pinSel - PIN_SEL_FIRST] : 1'b0;
  assign pinActive = selValid & (pinSelect_q[PIN_POLARITY_BIT] ? selLevel : ~selLevel);
  assign pinEnabled = pinActive & (pinTime_q != 7'h00);
  assign unitDone = tickRc & (pinTicks_q == PIN_TICKS_PER_UNIT - 13'h1);

  always_comb
  begin
    pinState_d = pinState_q;
    case (pinState_q)
      PR_IDLE: if (pinEnabled) pinState_d = PR_COUNT;
      PR_COUNT:
      begin
        if (!pinEnabled) pinState_d = PR_IDLE;
        else if (unitDone && pinUnits_q + 7'h01 == pinTime_q) pinState_d = PR_FIRED;
      end
      PR_FIRED: if (!pinEnabled) pinState_d = PR_IDLE;
      default: pinState_d = PR_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pinState_q <= PR_IDLE;
      pinTicks_q <= 13'h0;
      pinUnits_q <= 7'h0;
    end
    else
    begin
      pinState_q <= pinState_d;
      if (pinState_d != PR_COUNT || pinState_q != PR_COUNT)
      begin
        pinTicks_q <= 13'h0;
        pinUnits_q <= 7'h0;
      end
      else if (unitDone)
      begin
        pinTicks_q <= 13'h0;
        pinUnits_q <= pinUnits_q + 7'h01;
      end
      else if (tickRc) pinTicks_q <= pinTicks_q + 13'h1;
    end
  end

  // ************************************************
  // reference refresh and supervisor outputs
  // ************************************************
  logic [18:0] refreshCycles_q;
  logic [11:0] refreshCount_q;
  logic unitTick;
  logic refreshFire;
  logic wakeNow;

  assign unitTick = (refreshCycles_q == REFRESH_LAST);
  // a zero interval would mean refreshing continuously, so it stops refresh instead
  assign refreshFire = unitTick & (refreshUnits_q != 12'h0) & (refreshCount_q + 12'h1 >= refreshUnits_q);
  assign wakeNow = sHibernating & ~sWakeTree;
  assign eventSet = {wakeNow & ~wakeRequest_q, pinState_d == PR_FIRED && pinState_q != PR_FIRED, xtalFire};

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      refreshCycles_q <= 19'h0;
      refreshCount_q <= 12'h0;
      bandgapRefresh_q <= 1'b0;
      porReset_q <= 1'b0;
      railReset_q <= 1'b0;
      wakeRequest_q <= 1'b0;
      hibernate_wake_sense <= 1'b0;
      clk32kPrev_q <= 1'b0;
      slowRcPrev_q <= 1'b0;
    end
    else
    begin
      refreshCycles_q <= unitTick ? 19'h0 : refreshCycles_q + 19'h1;
      if (refreshFire) refreshCount_q <= 12'h0;
      else if (unitTick) refreshCount_q <= refreshCount_q + 12'h1;
      bandgapRefresh_q <= refreshFire;
      porReset_q <= padActive | (pinState_d == PR_FIRED);
      railReset_q <= (~sRailHigh & ~control_q[CTL_MASK_RAIL_HIGH]) | (~sRailLow & ~control_q[CTL_MASK_RAIL_LOW]);
      wakeRequest_q <= wakeNow;
      hibernate_wake_sense <= control_q[CTL_WAKE_SENSE];
      clk32kPrev_q <= clk32kSync;
      slowRcPrev_q <= slowRcSync;
    end
  end

  // ************************************************
  // checks
  // ************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  a_wake_request: assert property (wakeNow |=> wakeRequest_q) else $error("wake not requested");
  a_rail_reset: assert property ((!sRailHigh && !control_q[CTL_MASK_RAIL_HIGH]) |=> railReset_q)
    else $error("rail reset missing");
  a_boost_bit: assert property ((xfer && !pwrite && hitStatus) |->
    prdata[ST_BOOST] == $past(sBoost) && prdata[ST_BANDGAP] == $past(sBandgap)) else $error("status bits wrong");
  a_low_reg_gate: assert property (!sLowHighCur |-> !statusWord[ST_LOW_REG]) else $error("low flag shown");
  a_xtal_zero: assert property (readyCount_q == 8'h00 |-> !xtalFire) else $error("zero count fired");
  a_xtal_once: assert property (xtalFire |=> !xtalFire) else $error("crystal fired twice");
  a_pin_disabled: assert property ((pinTime_q == 7'h00 || !selValid) |=> pinState_q == PR_IDLE)
    else $error("disabled pin reset ran");
  a_pad_reset: assert property (padActive |=> porReset_q) else $error("pad reset ignored");
  a_pin_fire: assert property ((pinState_q == PR_FIRED && pinEnabled) |=> porReset_q)
    else $error("pin reset not driven");
  a_refresh_off: assert property (refreshUnits_q == 12'h0 |=> !bandgapRefresh_q)
    else $error("refresh while off");
  a_status_ro: assert property ((wr && hitStatus) |=> $stable(startTrim_q) && statusWord[11] == 1'b0)
    else $error("status write effect");
  a_apb_ready: assert property ((accessPhase && !pready) |=> pready ##1 !pready) else $error("apb ready timing");

  c_xtal_ready: cover property (xtalFire);
  c_pin_reset: cover property (pinState_q == PR_COUNT ##1 pinState_q == PR_FIRED);
  c_refresh: cover property (bandgapRefresh_q);
  c_wake: cover property (wakeRequest_q && crystal_ready_interrupt);

endmodule
`default_nettype wire

// [sim/pin_source.sv]
// external reset source driving the gpio pins
`timescale 1ns/1ps
`default_nettype none
module pin_source (
  // clock
  input wire logic clk,
  // bench control
  input wire logic [3:0] sel,
  input wire logic activeHigh,
  input wire logic press,
  // gpio levels
  output logic [11:0] pins
);
  logic [11:0] idle_q = 12'h5a5;
  // unselected pins flip every cycle, which the synchroniser never accepts, so a wrong select sees a steady zero
  always @(posedge clk)
  begin
    idle_q <= ~idle_q;
  end
  always_comb
  begin
    pins = idle_q;
    if (sel >= 4'h1 && sel <= 4'hc)
      pins[sel-4'h1] = press ? activeHigh : ~activeHigh;
  end
endmodule
`default_nettype wire

// [sim/testbench.sv]
// self-checking bench for the power status and pin reset block
`timescale 1ns/1ps
`default_nettype none
module testbench
  import power_status_pkg::*;
;
  localparam int RC = 20;
  logic clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, slowRc = 0, clk32k = 0;
  logic resetPad_n = 1, press = 0, actHi = 0, errv, pready, pslverr;
  logic porReset, railReset, wakeReq, bgRefresh, wakeSense, irq;
  logic [3:0] sel = 4'h0;
  logic [13:0] ana = 14'h0;
  logic [11:0] pins;
  logic [31:0] paddr = 32'h0, pwdata = 32'h0, prdata, rdv, seed = 32'h2d30;
  int failures = 0, total_checks = 0, n;
  logic [31:0] regIdx[6] = '{IDX_CRYSTAL_START_TRIM, IDX_CRYSTAL_READY_DELAY, IDX_CRYSTAL_CORE_CONTROL,
    IDX_PIN_RESET_SELECT, IDX_PIN_RESET_TIMER, IDX_REFERENCE_REFRESH_INTERVAL};
  logic [31:0] regMask[6] = '{32'hffff, 32'hff, 32'hff, 32'hff, 32'h7f, 32'hfff};
  logic [31:0] regRst[6] = '{32'haa, 32'h0, 32'h15, 32'h0, 32'h18, 32'h80};
  always #2 clk = ~clk;
  always #16 slowRc = ~slowRc;
  always #20 clk32k = ~clk32k;
  power_status_and_pin_reset #(.REFRESH_CYCLES(RC)) dut_u (.clk(clk), .rst_n(rst_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .railHighGood(ana[0]), .railLowGood(ana[1]),
    .boostDetected(ana[2]), .bandgapGood(ana[3]), .switcher_output_good(ana[4]),
    .core_regulator_good(ana[5]), .low_regulator_good(ana[6]), .lowRegHighCurrent(ana[7]),
    .crystal_regulator_good(ana[8]), .converter_regulator_good(ana[9]), .compHighOk(ana[10]),
    .compHighNok(ana[11]), .wake_tree_output(ana[12]), .hibernating(ana[13]), .clk32k(clk32k),
    .slow_rc_clock(slowRc), .portPins(pins), .resetPad_n(resetPad_n), .porReset_q(porReset),
    .railReset_q(railReset), .wakeRequest_q(wakeReq), .bandgapRefresh_q(bgRefresh),
    .hibernate_wake_sense(wakeSense), .crystal_ready_interrupt(irq));
  pin_source src_u (.clk(clk), .sel(sel), .activeHigh(actHi), .press(press), .pins(pins));
  function automatic logic [31:0] lfsr(input logic [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // expected status word built from the monitor levels
  function automatic logic [31:0] statusOf(input logic [13:0] a);
    statusOf = {19'h0, a[12], 1'b0, a[9], a[8], a[2], a[0], a[1], a[3], a[11], a[10], a[4], a[6] & a[7], a[5]};
  endfunction
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic apb(input logic w, input logic [31:0] idx, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {idx[29:0], 2'b00};
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    k = 0;
    do
    begin
      @(posedge clk);
      k++;
    end
    while (pready !== 1'b1 && k < 50);
    if (k >= 50)
      failures++;
    rdv = prdata;
    errv = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #400000;
    failures++;
    print_verdict();
  end
  initial
  begin
    cyc(10);
    rst_n <= 1'b1;
    foreach (regIdx[i])
    begin
      apb(1'b0, regIdx[i], 32'h0);
      chk(rdv, regRst[i]);
      seed = lfsr(seed);
      apb(1'b1, regIdx[i], seed);
      apb(1'b0, regIdx[i], 32'h0);
      chk(rdv, seed & regMask[i]);
      apb(1'b1, regIdx[i], regRst[i]);
    end
    repeat (8)
    begin
      seed = lfsr(seed);
      ana <= seed[13:0];
      cyc(8);
      apb(1'b1, IDX_ANALOG_STATUS, 32'hffff);
      apb(1'b0, IDX_ANALOG_STATUS, 32'h0);
      chk(rdv, statusOf(ana));
    end
    apb(1'b0, 32'h50000070, 32'h0);
    chk({rdv[30:0], errv}, 32'h1);
    // low rail fails while hibernating with the wake tree at zero
    ana <= 14'h2ffd;
    cyc(8);
    chk(railReset, 1'b1);
    chk(wakeReq, 1'b1);
    apb(1'b1, IDX_SUPERVISOR_CONTROL, 32'ha);
    cyc(4);
    chk(railReset, 1'b0);
    chk(wakeSense, 1'b1);
    ana <= 14'h1fff;
    apb(1'b1, IDX_CRYSTAL_READY_DELAY, 32'h8);
    apb(1'b1, IDX_EVENT_ENABLE, 32'h1);
    apb(1'b1, IDX_SUPERVISOR_CONTROL, 32'h1);
    for (n = 0; n < 200 && irq !== 1'b1; n++)
      @(posedge clk);
    chk(n >= 70 && n <= 90, 1'b1);
    chk(wakeSense, 1'b0);
    apb(1'b1, IDX_EVENT_ENABLE, 32'h0);
    cyc(2);
    chk(irq, 1'b0);
    apb(1'b1, IDX_EVENT_ENABLE, 32'h1);
    cyc(2);
    chk(irq, 1'b1);
    apb(1'b1, IDX_EVENT_CLEAR, 32'h1);
    cyc(2);
    chk(irq, 1'b0);
    apb(1'b1, IDX_SUPERVISOR_CONTROL, 32'h0);
    apb(1'b1, IDX_CRYSTAL_READY_DELAY, 32'h0);
    apb(1'b1, IDX_SUPERVISOR_CONTROL, 32'h1);
    cyc(100);
    chk(irq, 1'b0);
    apb(1'b1, IDX_REFERENCE_REFRESH_INTERVAL, 32'h2);
    for (n = 0; n < 3000 && bgRefresh !== 1'b1; n++)
      @(posedge clk);
    @(posedge clk);
    for (n = 1; n < 200 && bgRefresh !== 1'b1; n++)
      @(posedge clk);
    chk(n, 2 * RC);
    // last select value, one time unit: active low first, then active high
    apb(1'b1, IDX_PIN_RESET_TIMER, 32'h1);
    for (int p = 0; p < 2; p++)
    begin
      actHi <= p[0];
      sel <= 4'hc;
      press <= 1'b1;
      cyc(8);
      apb(1'b1, IDX_PIN_RESET_SELECT, {24'h0, p[0], 7'h0c});
      for (n = 0; n < 5000 && porReset !== 1'b1; n++)
        @(posedge slowRc);
      chk(n >= 4096 && n <= 4098, 1'b1);
      apb(1'b0, IDX_EVENT_STATUS, 32'h0);
      chk(rdv[1], 1'b1);
      apb(1'b1, IDX_EVENT_CLEAR, 32'h2);
      press <= 1'b0;
      apb(1'b1, IDX_PIN_RESET_SELECT, 32'h80);
      cyc(10);
      chk(porReset, 1'b0);
    end
    resetPad_n <= 1'b0;
    cyc(10);
    chk(porReset, 1'b1);
    resetPad_n <= 1'b1;
    cyc(10);
    print_verdict();
  end
endmodule
`default_nettype wire
